/* File: src/ppc_defs.svh */
// register offsets, field positions and reset values of the port pull-up and change block
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH
`define PPC_OFF_PORT      8'h00
`define PPC_OFF_DIR       8'h04
`define PPC_OFF_PULLUP    8'h08
`define PPC_OFF_CHGEN     8'h0c
`define PPC_OFF_ANALOG    8'h10
`define PPC_OFF_CTRL      8'h14
`define PPC_OFF_IRQ_STAT  8'h18
`define PPC_OFF_IRQ_EN    8'h1c
`define PPC_OFF_IRQ_CLR   8'h20
`define PPC_OFF_CONFIG    8'h24
`define PPC_PIN_THREE     3
`define PPC_PIN_FOUR      4
`define PPC_PIN_FIVE      5
`define PPC_ANALOG_BIT_TWO 2
`define PPC_CTRL_GLOBAL_IRQ 0
`define PPC_CTRL_FLAG     1
`define PPC_CTRL_GPUD     2
`define PPC_CFG_MASTER_CLEAR 0
`define PPC_CFG_OSC_LO    1
`define PPC_CFG_OSC_HI    3
`define PPC_CFG_REDUCED   4
`define PPC_CONV_CLK_LO   4
`define PPC_CONV_CLK_HI   6
`define PPC_ANALOG_HI     3
`define PPC_PULLUP_RST    6'h37
`define PPC_CHGEN_RST     6'h00
`define PPC_ANALOG_RST    4'hf
`define PPC_CONV_CLK_RST  3'h0
`define PPC_DIR_RST       6'h3f
`define PPC_PORT_RST      6'h00
`define PPC_IRQ_CHANGE    0
`define PPC_IRQ_WAKE      1
`define PPC_IRQ_W         2
`endif

/* File: src/ppc_pkg.sv */
// types of the port pull-up and change block
package ppc_pkg;
  typedef enum logic [2:0]
  {
    PPC_OSC_LOW_POWER  = 3'h0,
    PPC_OSC_CRYSTAL    = 3'h1,
    PPC_OSC_HIGH_SPEED = 3'h2,
    PPC_OSC_EXTRC = 3'h3,
    PPC_OSC_INT  = 3'h4
  } ppc_osc_t;
  typedef enum logic [1:0]
  {
    PPC_BUS_IDLE = 2'b00,
    PPC_BUS_ACK  = 2'b01,
    PPC_BUS_DONE = 2'b11
  } ppc_bus_t;
  typedef enum logic [2:0]
  {
    PPC_DIV2  = 3'h0,
    PPC_DIV8  = 3'h1,
    PPC_DIV32 = 3'h2,
    PPC_RC0   = 3'h3,
    PPC_DIV4  = 3'h4,
    PPC_DIV16 = 3'h5,
    PPC_DIV64 = 3'h6,
    PPC_RC1   = 3'h7
  } ppc_conv_clk_t;
endpackage

/* File: src/ppc_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i)
  begin
    meta_r <= d_i;
    q_o    <= meta_r;
  end
endmodule
`default_nettype wire

/* File: src/ppc_adclk.sv */
// converter clock select decode into a divisor and an rc-clock flag
`timescale 1ns/1ps
`default_nettype none
module ppc_adclk (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] sel_i,
  output var  logic [6:0] div_o,
  output var  logic       rc_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_o <= 7'h02;
      rc_o  <= 1'b0;
    end
    else
    begin
      rc_o <= 1'b0;
      case (ppc_pkg::ppc_conv_clk_t'(sel_i))
        ppc_pkg::PPC_DIV2:  div_o <= 7'h02;
        ppc_pkg::PPC_DIV4:  div_o <= 7'h04;
        ppc_pkg::PPC_DIV8:  div_o <= 7'h08;
        ppc_pkg::PPC_DIV16: div_o <= 7'h10;
        ppc_pkg::PPC_DIV32: div_o <= 7'h20;
        ppc_pkg::PPC_DIV64: div_o <= 7'h40;
        default:
        begin
          div_o <= 7'h00;
          rc_o  <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/ppc_top.sv */
// port pull-up, change-interrupt and analog-select block with a wishbone slave
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defs.svh"
module ppc_top #(
  parameter int  PINS    = 6,
  parameter logic REDUCED = 1'b0
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            por_i,
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  input  wire logic            we_i,
  input  wire logic [7:0]      adr_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic [31:0]     dat_i,
  output var  logic [31:0]     dat_o,
  output var  logic            ack_o,
  output var  logic            err_o,
  input  wire logic [PINS-1:0] pin_i,
  input  wire logic            master_clear_cfg_i,
  input  wire logic [2:0]      osc_mode_i,
  input  wire logic            sleep_i,
  output var  logic [PINS-1:0] pin_o,
  output var  logic [PINS-1:0] pin_oe_o,
  output var  logic [PINS-1:0] pullup_o,
  output var  logic [3:0]      analog_o,
  output var  logic [6:0]      adc_div_o,
  output var  logic            adc_rc_o,
  output var  logic            wake_o,
  output var  logic            irq_o
);
  logic [PINS-1:0] sync_w;
  logic [PINS-1:0] last_read_r;
  logic [PINS-1:0] out_latch_r;
  logic [PINS-1:0] dir_r;
  logic [PINS-1:0] pullup_en_r;
  logic [PINS-1:0] chg_en_r;
  logic [3:0]      analog_r;
  logic [2:0]      conv_clk_sel_r;
  logic            global_irq_en_r;
  logic            flag_r;
  logic            gpud_r;
  logic [`PPC_IRQ_W-1:0] irq_stat_r;
  logic [`PPC_IRQ_W-1:0] irq_en_r;
  logic            osc_force;
  logic [PINS-1:0] ana_pin;
  logic [PINS-1:0] dig_in;
  logic [PINS-1:0] pullup_rd;
  logic [PINS-1:0] chg_rd;
  logic [PINS-1:0] mismatch;
  logic [PINS-1:0] pullup_nxt;
  logic [3:0]      analog_mask;
  logic            req;
  logic            wr;
  logic            rd;
  logic            port_acc;
  logic            port_rd;
  logic            any_mis;
  logic [31:0]     rdata;
  logic            hit;
  logic [`PPC_IRQ_W-1:0] irq_evt;

  // pin levels synchronised before any compare
  ppc_sync #(.W(PINS)) u_sync (
    .clk_i (clk_i),
    .d_i   (pin_i),
    .q_o   (sync_w)
  );

  ppc_adclk u_adclk (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sel_i (conv_clk_sel_r),
    .div_o (adc_div_o),
    .rc_o  (adc_rc_o)
  );

  // crystal-type modes own pins five and four
  assign osc_force = (osc_mode_i == ppc_pkg::PPC_OSC_LOW_POWER) ||
                     (osc_mode_i == ppc_pkg::PPC_OSC_CRYSTAL) ||
                     (osc_mode_i == ppc_pkg::PPC_OSC_HIGH_SPEED);
  assign analog_mask = REDUCED ? 4'hb : 4'hf;

  // analog bits 3..0 map to pins four, two, one, zero
  always_comb
  begin
    ana_pin = '0;
    ana_pin[0] = analog_r[0];
    ana_pin[1] = analog_r[1];
    ana_pin[2] = analog_r[`PPC_ANALOG_BIT_TWO];
    ana_pin[`PPC_PIN_FOUR] = analog_r[`PPC_ANALOG_HI];
  end

  assign dig_in   = sync_w & ~ana_pin;
  assign mismatch = (dig_in ^ last_read_r) & chg_en_r & ~ana_pin;
  assign any_mis  = |mismatch;

  // reads of enables: pin three pull-up zero, forced ones in crystal modes
  always_comb
  begin
    pullup_rd = pullup_en_r;
    pullup_rd[`PPC_PIN_THREE] = 1'b0;
    chg_rd = chg_en_r;
    if (osc_force)
    begin
      pullup_rd[`PPC_PIN_FIVE] = 1'b1;
      pullup_rd[`PPC_PIN_FOUR] = 1'b1;
      chg_rd[`PPC_PIN_FIVE]    = 1'b1;
      chg_rd[`PPC_PIN_FOUR]    = 1'b1;
    end
  end

  // pull-up drive per pin
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      pullup_nxt[i] = pullup_rd[i] & dir_r[i] & ~gpud_r & ~ana_pin[i];
    end
    pullup_nxt[`PPC_PIN_THREE] = master_clear_cfg_i;
  end

  // one take per request: a pending answer blocks a second
  assign req      = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr       = req & we_i & sel_i[0];
  assign rd       = req & ~we_i;
  assign port_acc = req & (adr_i == `PPC_OFF_PORT);
  // any port access refreshes the latch and ends the mismatch
  assign port_rd  = port_acc;

  // address decode for reads
  always_comb
  begin
    rdata = '0;
    hit   = 1'b1;
    if (adr_i == `PPC_OFF_PORT)
      rdata[PINS-1:0] = dig_in;
    else if (adr_i == `PPC_OFF_DIR)
      rdata[PINS-1:0] = dir_r | 6'h08;
    else if (adr_i == `PPC_OFF_PULLUP)
      rdata[PINS-1:0] = pullup_rd;
    else if (adr_i == `PPC_OFF_CHGEN)
      rdata[PINS-1:0] = chg_rd;
    else if (adr_i == `PPC_OFF_ANALOG)
    begin
      rdata[3:0] = analog_r & analog_mask;
      rdata[`PPC_CONV_CLK_HI:`PPC_CONV_CLK_LO] = REDUCED ? 3'h0 : conv_clk_sel_r;
    end
    else if (adr_i == `PPC_OFF_CTRL)
    begin
      rdata[`PPC_CTRL_GLOBAL_IRQ] = global_irq_en_r;
      rdata[`PPC_CTRL_FLAG] = flag_r;
      rdata[`PPC_CTRL_GPUD] = gpud_r;
    end
    else if (adr_i == `PPC_OFF_IRQ_STAT)
      rdata[`PPC_IRQ_W-1:0] = irq_stat_r;
    else if (adr_i == `PPC_OFF_IRQ_EN)
      rdata[`PPC_IRQ_W-1:0] = irq_en_r;
    else if (adr_i == `PPC_OFF_IRQ_CLR)
      rdata = '0;
    else if (adr_i == `PPC_OFF_CONFIG)
    begin
      rdata[`PPC_CFG_MASTER_CLEAR] = master_clear_cfg_i;
      rdata[`PPC_CFG_OSC_HI:`PPC_CFG_OSC_LO] = osc_mode_i;
      rdata[`PPC_CFG_REDUCED] = REDUCED;
    end
    else
      hit = 1'b0;
  end

  // bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      dat_o <= (rd & hit) ? rdata : '0;
    end
  end

  // last-read latch: only power-on clears it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
      last_read_r <= `PPC_PORT_RST;
    else if (port_rd)
      last_read_r <= dig_in;
  end

  // port output latch and direction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_latch_r <= `PPC_PORT_RST;
      dir_r       <= `PPC_DIR_RST;
    end
    else if (wr && adr_i == `PPC_OFF_PORT)
      out_latch_r <= dat_i[PINS-1:0];
    else if (wr && adr_i == `PPC_OFF_DIR)
    begin
      dir_r <= dat_i[PINS-1:0];
      dir_r[`PPC_PIN_THREE] <= 1'b1;
    end
  end

  // pull-up and change enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pullup_en_r <= `PPC_PULLUP_RST;
      chg_en_r    <= `PPC_CHGEN_RST;
    end
    else if (wr && adr_i == `PPC_OFF_PULLUP)
    begin
      pullup_en_r <= dat_i[PINS-1:0];
      pullup_en_r[`PPC_PIN_THREE] <= 1'b0;
    end
    else if (wr && adr_i == `PPC_OFF_CHGEN)
      chg_en_r <= dat_i[PINS-1:0];
  end

  // analog select and converter clock field
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      analog_r       <= `PPC_ANALOG_RST & analog_mask;
      conv_clk_sel_r <= `PPC_CONV_CLK_RST;
    end
    else if (wr && adr_i == `PPC_OFF_ANALOG)
    begin
      analog_r <= dat_i[3:0] & analog_mask;
      if (!REDUCED)
        conv_clk_sel_r <= dat_i[`PPC_CONV_CLK_HI:`PPC_CONV_CLK_LO];
    end
  end

  // control: global irq enable, pull-up global disable, change flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      global_irq_en_r <= 1'b0;
      gpud_r          <= 1'b1;
    end
    else if (wr && adr_i == `PPC_OFF_CTRL)
    begin
      global_irq_en_r <= dat_i[`PPC_CTRL_GLOBAL_IRQ];
      gpud_r          <= dat_i[`PPC_CTRL_GPUD];
    end
  end

  // flag: mismatch sets it and wins over a clear; no set during a port access
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_r <= 1'b0;
    else if (any_mis && !port_acc)
      flag_r <= 1'b1;
    else if (wr && adr_i == `PPC_OFF_CTRL && !dat_i[`PPC_CTRL_FLAG])
      flag_r <= 1'b0;
  end

  // change raises the change bit only with the global enable, and the wake bit only during sleep
  assign irq_evt[`PPC_IRQ_CHANGE] = flag_r & global_irq_en_r;
  assign irq_evt[`PPC_IRQ_WAKE]   = flag_r & sleep_i;

  // sticky status, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end
    else
    begin
      if (wr && adr_i == `PPC_OFF_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~dat_i[`PPC_IRQ_W-1:0]) | irq_evt;
      else
        irq_stat_r <= irq_stat_r | irq_evt;
      if (wr && adr_i == `PPC_OFF_IRQ_EN)
        irq_en_r <= dat_i[`PPC_IRQ_W-1:0];
    end
  end

  // registered pin-side and interrupt outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o    <= '0;
      pin_oe_o <= '0;
      pullup_o <= '0;
      // analog pins stay analog through reset
      analog_o <= `PPC_ANALOG_RST & analog_mask;
      wake_o   <= 1'b0;
      irq_o    <= 1'b0;
    end
    else
    begin
      pin_o    <= out_latch_r;
      pin_oe_o <= ~dir_r & ~6'h08;
      pullup_o <= pullup_nxt;
      analog_o <= analog_r & analog_mask;
      wake_o   <= flag_r & sleep_i;
      irq_o    <= |(irq_stat_r & irq_en_r);
    end
  end
endmodule
`default_nettype wire

/* File: tb/ppc_top_properties.sv */
// concurrent checks on the ports of the port pull-up and change block
`timescale 1ns/1ps
`default_nettype none
module ppc_top_properties #(
  parameter int PINS = 6
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic [31:0]     dat_o,
  input wire logic            ack_o,
  input wire logic            err_o,
  input wire logic            master_clear_cfg_i,
  input wire logic            sleep_i,
  input wire logic [PINS-1:0] pin_oe_o,
  input wire logic [PINS-1:0] pullup_o,
  input wire logic [3:0]      analog_o,
  input wire logic [6:0]      adc_div_o,
  input wire logic            adc_rc_o,
  input wire logic            wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_ans;
    ack_o || err_o;
  endsequence
  property p_answer; s_req |=> s_ans; endproperty
  property p_pulse; ack_o |=> !ack_o; endproperty
  property p_cause; s_ans |-> $past(cyc_i && stb_i); endproperty
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  property p_pu_out; (pullup_o & pin_oe_o) == '0; endproperty
  property p_pu_three; pullup_o[3] |-> $past(master_clear_cfg_i); endproperty
  property p_wake; wake_o |-> $past(sleep_i); endproperty
  property p_rc; adc_rc_o |-> adc_div_o == 7'h00; endproperty
  property p_rst; $fell(rst_i) |-> pullup_o == '0 && analog_o == 4'hf && adc_div_o == 7'h02; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");
  a_pu_three: assert property (p_pu_three) else $error("pin three pull-up without master clear");
  a_wake: assert property (p_wake) else $error("wake while awake");
  a_rc: assert property (p_rc) else $error("divisor with rc clock");
  a_rst: assert property (p_rst) else $error("bad reset outputs");
endmodule
bind ppc_top ppc_top_properties #(.PINS(PINS)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .master_clear_cfg_i(master_clear_cfg_i),
  .sleep_i(sleep_i),
  .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .analog_o(analog_o), .adc_div_o(adc_div_o),
  .adc_rc_o(adc_rc_o), .wake_o(wake_o));
`default_nettype wire

/* File: tb/ppc_pins.sv */
// external circuitry on the six port pins
`timescale 1ns/1ps
`default_nettype none
module ppc_pins (
  input  wire logic       clk_i,
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe_o,
  input  wire logic [5:0] pullup_o,
  input  wire logic [5:0] ext_d_i,
  input  wire logic [5:0] ext_en_i,
  output var  logic [5:0] pin_i
);
  logic [5:0] float_r = 6'h00;
  // undriven pins wander every cycle
  always_ff @(posedge clk_i)
    float_r <= ~pin_i;
  always_comb
    for (int k = 0; k < 6; k++)
      pin_i[k] = pin_oe_o[k] ? pin_o[k] : ext_en_i[k] ? ext_d_i[k] : pullup_o[k] ? 1'b1 : float_r[k];
endmodule
`default_nettype wire

/* File: tb/ppc_top_tb_top.sv */
// self-checking bench of the port pull-up and change block
`timescale 1ns/1ps
`default_nettype none
module ppc_top_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        master_clear_cfg_i = 1'b0, sleep_i = 1'b0, ack_o, err_o, adc_rc_o, wake_o, irq_o;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h43b723ac;
  logic [2:0]  osc_mode_i = 3'h4;
  logic [5:0]  pin_i, pin_o, pin_oe_o, pullup_o, ext_d = 6'h00;
  logic [3:0]  analog_o;
  logic [6:0]  adc_div_o;
  logic [6:0]  dv [8] = '{7'h02, 7'h08, 7'h20, 7'h00, 7'h04, 7'h10, 7'h40, 7'h00};
  logic [32:0] exp_q [$];
  int          n_fail = 0, check_count = 0;
  always #20 clk_i = ~clk_i;
  ppc_top dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pin_i(pin_i),
    .master_clear_cfg_i(master_clear_cfg_i), .osc_mode_i(osc_mode_i), .sleep_i(sleep_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_o(pullup_o), .analog_o(analog_o), .adc_div_o(adc_div_o), .adc_rc_o(adc_rc_o), .wake_o(wake_o),
    .irq_o(irq_o));
  ppc_pins u_pins (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .ext_d_i(ext_d),
    .ext_en_i(6'h3f), .pin_i(pin_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] e);
    check_count++;
    if (seen !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1 && err_o !== 1'b1)
      n_fail++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task automatic wait_chk(input string nm, input logic seen_sel, input logic e);
    repeat (5) @(posedge clk_i);
    check(nm, 33'(seen_sel ? wake_o : irq_o), 33'(e));
  endtask
  always @(posedge clk_i)
    if (ack_o === 1'b1 || err_o === 1'b1)
      check("bus", {err_o, dat_o}, exp_q.pop_front());
  initial
  begin
    #400000;
    n_fail++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 32'h37);
    rd(8'h04, 32'h3f);
    rd(8'h0c, 32'h00);
    rd(8'h10, 32'h0f);
    rd(8'h14, 32'h04);
    bus(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
    wr(8'h08, 32'hff);
    rd(8'h08, 32'h37);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h3f);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h7f);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, {25'h0, 3'(c), 4'h0});
      check("adclk", {25'h0, adc_rc_o, adc_div_o}, {25'h0, 3'(c) inside {3'h3, 3'h7}, dv[c]});
    end
    wr(8'h14, 32'h00);
    wr(8'h04, 32'h00);
    wr(8'h08, 32'h3f);
    check("pu_out", 33'(pullup_o), 33'h0);
    check("pin_oe", 33'(pin_oe_o), 33'h37);
    repeat (3)
    begin
      seed = xs(seed);
      wr(8'h00, seed);
      check("pin_o", 33'(pin_o), 33'(seed[5:0]));
    end
    wr(8'h04, 32'h3f);
    check("pu_in", 33'(pullup_o), 33'h37);
    master_clear_cfg_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("pu_master_clear_pin", 33'(pullup_o), 33'h3f);
    wr(8'h10, 32'h0f);
    check("pu_analog", 33'(pullup_o), 33'h28);
    check("analog", 33'(analog_o), 33'h0f);
    osc_mode_i <= 3'h1;
    wr(8'h08, 32'h00);
    rd(8'h08, 32'h30);
    wr(8'h0c, 32'h00);
    rd(8'h0c, 32'h30);
    osc_mode_i <= 3'h4;
    wr(8'h10, 32'h00);
    wr(8'h0c, 32'h01);
    wr(8'h1c, 32'h03);
    rd(8'h00, 32'h00);
    wr(8'h14, 32'h00);
    rd(8'h14, 32'h00);
    ext_d <= 6'h01;
    wait_chk("irq_nogie", 1'b0, 1'b0);
    rd(8'h14, 32'h02);
    wr(8'h14, 32'h01);
    wait_chk("irq_set", 1'b0, 1'b1);
    sleep_i <= 1'b1;
    wait_chk("wake", 1'b1, 1'b1);
    sleep_i <= 1'b0;
    wr(8'h1c, 32'h00);
    wait_chk("irq_mask", 1'b0, 1'b0);
    wr(8'h1c, 32'h03);
    wr(8'h14, 32'h01);
    wr(8'h20, 32'h03);
    wait_chk("irq_persist", 1'b0, 1'b1);
    rd(8'h00, 32'h01);
    wr(8'h10, 32'h01);
    rd(8'h00, 32'h00);
    wr(8'h10, 32'h00);
    rd(8'h00, 32'h01);
    wr(8'h14, 32'h01);
    wr(8'h20, 32'h03);
    wait_chk("irq_clear", 1'b0, 1'b0);
    ext_d <= 6'h00;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h10, 32'h00);
    wr(8'h0c, 32'h01);
    wr(8'h1c, 32'h01);
    wr(8'h14, 32'h01);
    wait_chk("irq_keep", 1'b0, 1'b1);
    results();
  end
endmodule
`default_nettype wire
